// File: hdl/adc_compute_pkg.sv
// Constants, register map and field types of the ADC computation control block
package adc_compute_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [11:0] IDX_COMPUTE_CONTROL   = 12'h3F5;
  localparam logic [11:0] IDX_THRESHOLD_CONTROL = 12'h3F6;
  localparam logic [11:0] IDX_COMPUTE_CONDITION = 12'h3F7;
  localparam logic [11:0] IDX_AUX_CONTROL       = 12'h3E0;
  localparam logic [11:0] IDX_SETPOINT          = 12'h3E1;
  localparam logic [11:0] IDX_UPPER_THRESHOLD   = 12'h3E2;
  localparam logic [11:0] IDX_LOWER_THRESHOLD   = 12'h3E3;
  localparam logic [11:0] IDX_REPEAT_TARGET     = 12'h3E4;
  localparam logic [11:0] IDX_ERROR_VALUE       = 12'h3E5;
  localparam logic [11:0] IDX_FILTER_VALUE      = 12'h3E6;
  localparam logic [11:0] IDX_PREVIOUS_VALUE    = 12'h3E7;
  localparam logic [11:0] IDX_ACCUMULATOR       = 12'h3E8;
  localparam logic [11:0] IDX_SAMPLE_COUNTER    = 12'h3E9;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int          ACCUMULATOR_CLEAR_BIT     = 3;
  localparam int          OVF_BIT      = 7;
  localparam int          UPD_BIT      = 4;
  localparam int          DOUBLE_SAMPLE_ENABLE_BIT     = 0;
  localparam int          AUTO_RETRIGGER_ENABLE_BIT     = 1;
  localparam int          GO_BIT       = 2;
  localparam logic [7:0]  CTRL_RESET   = 8'h00;
  localparam logic [15:0] WORD_RESET   = 16'h0000;

  // Operating modes, error formulas, phase codes
  localparam logic [2:0] MODE_BASIC  = 3'h0;
  localparam logic [2:0] MODE_ACCUM  = 3'h1;
  localparam logic [2:0] MODE_AVG    = 3'h2;
  localparam logic [2:0] MODE_BURST  = 3'h3;
  localparam logic [2:0] MODE_LPF    = 3'h4;
  localparam logic [2:0] ERROR_FORMULA_SELECT_RES_PREV  = 3'h0;
  localparam logic [2:0] ERROR_FORMULA_SELECT_RES_STPT  = 3'h1;
  localparam logic [2:0] ERROR_FORMULA_SELECT_RES_FLT   = 3'h2;
  localparam logic [2:0] ERROR_FORMULA_SELECT_PREV_FLT  = 3'h4;
  localparam logic [2:0] ERROR_FORMULA_SELECT_FLT_STPT  = 3'h5;
  localparam logic [2:0] PHASE_IDLE     = 3'h0;
  localparam logic [2:0] PHASE_WAIT     = 3'h4;

  // Accumulator clear time
  localparam int         CLK_NS       = 10;
  localparam int         CLEAR_NS     = 30;
  localparam int         CLEAR_CYCLES = (CLEAR_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [1:0] CLEAR_COUNT  = 2'(CLEAR_CYCLES);

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef logic        [11:0] sample_t;
  typedef logic signed [15:0] word_t;
  typedef logic signed [17:0] acc_t;

  typedef struct packed {
    logic       previous_source_select;
    logic [2:0] result_shift;
    logic       accumulator_clear;
    logic [2:0] operating_mode_select;
  } compute_control_t;

  typedef struct packed {
    logic       spare;
    logic [2:0] error_formula_select;
    logic       halt_on_irq;
    logic [2:0] threshold_irq_select;
  } threshold_control_t;

  typedef enum logic {
    PAIR_FIRST  = 1'b0,
    PAIR_SECOND = 1'b1
  } pair_state_t;

endpackage

// File: hdl/adc_computation_control.sv
// ADC computation control: APB registers, accumulate/filter, error and threshold test
// Notes on behaviour
// R1: Double sampling pairs conversions; computation runs only after every second one.
// R2: At conversion start previous value takes filter or result per source select.
// R3: Low-pass filter time constant is two to the shift field, unity gain.
// R4: Accumulate and average modes right-shift the accumulator by the shift field.
// R5: Basic mode ignores the shift field.
// R6: Software never programs a shift of zero.
// R7: Software sets repeat target to two to the shift for a true average.
// R8: Writing accumulator clear wipes accumulator, counter, overflow; reads one while busy.
// R9: Hardware drops the clear bit when clearing completes.
// R10: Mode field selects basic, accumulate, average, burst average, low-pass filter.
// R11: Error formula field picks one of five differences; others reserved.
// R12: Double sampling replaces result by result minus previous in two formulas.
// R13: Continuous with halt set clears go on threshold hit, else retriggers.
// R14: Continuous without halt: software must clear go itself.
// R15: Halt bit is ignored without continuous operation.
// R16: Threshold select: never, below, at-or-above, at-or-below, above, always.
// R17: Code 011 tests strictly between thresholds, 100 outside them.
// R18: Overflow flag set on accumulator, filter or error overflow; software clears.
// R19: Read-only flags show error above upper and below lower threshold.
// R20: Update flag set on computation; software clear ignored during phase 100.
// R21: Phase code reports idle and first or second stage of the pair.
// R22: Phase reads 100 between triggers with double sampling, no continuous mode.
// R23: Error and thresholds compare as signed two's complement.
`timescale 1ns/1ns
module adc_computation_control (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [15:0]              paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic                     conv_start,
  input  wire logic                     conv_done,
  input  wire adc_compute_pkg::sample_t conv_data,
  input  wire logic [1:0]               core_stage,
  output logic                          conv_go,
  output logic                          conv_retrigger,
  output logic                          threshold_hit
);
  import adc_compute_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  compute_control_t   ctrl,     next_ctrl;
  threshold_control_t thr,      next_thr;
  logic               double_sample_enable,     next_double_sample_enable;
  logic               auto_retrigger_enable,     next_auto_retrigger_enable;
  logic               go,       next_go;
  word_t              setpoint, next_setpoint;
  word_t              upper,    next_upper;
  word_t              lower,    next_lower;
  logic [7:0]         target,   next_target;
  logic [31:0]        rd_q,     next_prdata;
  sample_t            result,   next_result;
  word_t              previous, next_previous;
  word_t              filter,   next_filter;
  word_t              error,    next_error;
  acc_t               acc,      next_acc;
  logic [7:0]         count,    next_count;
  pair_state_t        pair,     next_pair;
  logic [1:0]         clr_cnt,  next_clr_cnt;
  logic               ovf,      next_ovf;
  logic               above,    next_above;
  logic               below,    next_below;
  logic               upd,      next_upd;
  logic               retrig,   next_retrig;
  logic               hit,      next_hit;

  logic        access, addr_ok, wr, rd_setup;
  logic [11:0] idx;
  logic [31:0] rd_val;
  logic        clr_busy, clr_start, stop_go;
  logic [2:0]  phase;
  logic        compute_now, test_now, done, burst_more, hit_now, ovf_now;
  word_t       s, err_new, filt_new, res_term;
  acc_t        acc_new, shifted;
  logic [18:0] sum;
  logic [17:0] diff;
  logic [7:0]  cnt_new;

  // Value fits the 16-bit signed registers
  function automatic logic fits16(input logic [17:0] v);
    fits16 = (v[17:15] == 3'b000) || (v[17:15] == 3'b111);
  endfunction

  // ----------------------------------------------------------------
  // APB slave: no wait state; read data is registered in the setup phase so it leaves a flip-flop
  // ----------------------------------------------------------------
  assign access   = psel & penable;
  assign rd_setup = psel & ~penable;
  assign idx      = paddr[13:2];
  assign pready   = access;
  assign pslverr  = access & ~addr_ok;
  assign wr       = access & pwrite & addr_ok;
  assign prdata   = rd_q;
  assign clr_busy = clr_cnt != 2'h0;
  // Phase code; pair flag marks the second stage
  assign phase    = (core_stage != 2'h0) ? {pair == PAIR_SECOND, core_stage} // R21
                  : (double_sample_enable && !auto_retrigger_enable && pair == PAIR_SECOND) ? PHASE_WAIT : PHASE_IDLE; // R22

  // Address decode and read mux; narrow registers sit in the low bits
  always_comb begin
    addr_ok = (paddr[15:14] == 2'h0) && (paddr[1:0] == 2'h0);
    rd_val  = 32'h0000_0000;
    unique case (idx)
      IDX_COMPUTE_CONTROL: begin
        rd_val[7:0] = {ctrl.previous_source_select, ctrl.result_shift, clr_busy,
                       ctrl.operating_mode_select}; // R8
      end
      IDX_THRESHOLD_CONTROL: rd_val[7:0] = {1'b0, thr[6:0]};
      IDX_COMPUTE_CONDITION: rd_val[7:0] = {ovf, above, below, upd, 1'b0, phase};
      IDX_AUX_CONTROL:       rd_val[2:0] = {go, auto_retrigger_enable, double_sample_enable};
      IDX_SETPOINT:          rd_val[15:0] = setpoint;
      IDX_UPPER_THRESHOLD:   rd_val[15:0] = upper;
      IDX_LOWER_THRESHOLD:   rd_val[15:0] = lower;
      IDX_REPEAT_TARGET:     rd_val[7:0] = target;
      IDX_ERROR_VALUE:       rd_val[15:0] = error;
      IDX_FILTER_VALUE:      rd_val[15:0] = filter;
      IDX_PREVIOUS_VALUE:    rd_val[15:0] = previous;
      IDX_ACCUMULATOR:       rd_val[17:0] = acc;
      IDX_SAMPLE_COUNTER:    rd_val[7:0] = count;
      default:               addr_ok = 1'b0;
    endcase
    next_prdata = rd_setup ? rd_val : rd_q;
  end

  // ----------------------------------------------------------------
  // Software control registers
  // ----------------------------------------------------------------
  // Software write of go wins over the hardware stop in the same cycle
  always_comb begin
    next_ctrl     = ctrl;
    next_thr      = thr;
    next_double_sample_enable     = double_sample_enable;
    next_auto_retrigger_enable     = auto_retrigger_enable;
    next_go       = stop_go ? 1'b0 : go; // R13
    next_setpoint = setpoint;
    next_upper    = upper;
    next_lower    = lower;
    next_target   = target;
    clr_start     = 1'b0;
    if (wr) begin
      unique case (idx)
        IDX_COMPUTE_CONTROL: begin
          next_ctrl = pwdata[7:0];
          next_ctrl.accumulator_clear = 1'b0;
          clr_start = pwdata[ACCUMULATOR_CLEAR_BIT] & ~clr_busy; // R8
        end
        IDX_THRESHOLD_CONTROL: next_thr = {1'b0, pwdata[6:0]};
        IDX_AUX_CONTROL: begin
          next_double_sample_enable = pwdata[DOUBLE_SAMPLE_ENABLE_BIT];
          next_auto_retrigger_enable = pwdata[AUTO_RETRIGGER_ENABLE_BIT];
          next_go   = pwdata[GO_BIT];
        end
        IDX_SETPOINT:        next_setpoint = pwdata[15:0];
        IDX_UPPER_THRESHOLD: next_upper    = pwdata[15:0];
        IDX_LOWER_THRESHOLD: next_lower    = pwdata[15:0];
        IDX_REPEAT_TARGET:   next_target   = pwdata[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl     <= CTRL_RESET;
      thr      <= CTRL_RESET;
      double_sample_enable     <= 1'b0;
      auto_retrigger_enable     <= 1'b0;
      go       <= 1'b0;
      setpoint <= WORD_RESET;
      upper    <= WORD_RESET;
      lower    <= WORD_RESET;
      target   <= 8'h00;
      rd_q     <= 32'h0000_0000;
    end else begin
      ctrl     <= next_ctrl;
      thr      <= next_thr;
      double_sample_enable     <= next_double_sample_enable;
      auto_retrigger_enable     <= next_auto_retrigger_enable;
      go       <= next_go;
      setpoint <= next_setpoint;
      upper    <= next_upper;
      lower    <= next_lower;
      target   <= next_target;
      rd_q     <= next_prdata;
    end
  end

  // ----------------------------------------------------------------
  // Computation datapath
  // ----------------------------------------------------------------
  // Sample is the new result, or its difference to previous when paired
  always_comb begin
    s        = double_sample_enable ? word_t'({4'h0, conv_data}) - previous : word_t'({4'h0, conv_data});
    compute_now = conv_done && (!double_sample_enable || pair == PAIR_SECOND); // R1
    // Average modes restart once the previous batch reached the target
    cnt_new  = (count == 8'hFF) ? count : count + 8'h01;
    sum      = {acc[17], acc} + {{3{s[15]}}, s};
    shifted  = acc >>> ctrl.result_shift;
    unique case (ctrl.operating_mode_select)
      MODE_AVG, MODE_BURST: begin
        if (count >= target) begin
          sum     = {{3{s[15]}}, s};
          cnt_new = 8'h01;
        end
      end
      MODE_LPF: begin
        sum = {acc[17], acc} - {shifted[17], shifted} + {{3{s[15]}}, s}; // R3
      end
      default: ;
    endcase
    acc_new  = sum[17:0];
    // Shift divides by a power of two; basic mode never reaches it
    filt_new = word_t'(acc_new >>> ctrl.result_shift); // R4
    ovf_now  = (sum[18] != sum[17]) || !fits16(acc_new >>> ctrl.result_shift); // R18
    done     = 1'b1;
    unique case (ctrl.operating_mode_select)
      MODE_ACCUM, MODE_LPF: ;
      MODE_AVG, MODE_BURST: begin
        done     = cnt_new >= target;
        filt_new = done ? filt_new : filter;
      end
      default: begin
        acc_new  = acc; // R5 R10
        cnt_new  = count;
        filt_new = filter;
        ovf_now  = 1'b0;
      end
    endcase
    burst_more = compute_now && ctrl.operating_mode_select == MODE_BURST && !done;
    test_now   = compute_now && done;
    // Error formula; paired mode swaps result for the pair difference
    res_term = double_sample_enable ? s : word_t'({4'h0, conv_data}); // R12
    unique case (thr.error_formula_select) // R11
      ERROR_FORMULA_SELECT_RES_PREV: diff = {{2{res_term[15]}}, res_term} - (double_sample_enable ? 18'h00000 :
                              {{2{previous[15]}}, previous});
      ERROR_FORMULA_SELECT_RES_STPT: diff = {{2{res_term[15]}}, res_term} - {{2{setpoint[15]}}, setpoint};
      ERROR_FORMULA_SELECT_RES_FLT:  diff = {{2{res_term[15]}}, res_term} - {{2{filt_new[15]}}, filt_new};
      ERROR_FORMULA_SELECT_PREV_FLT: diff = {{2{previous[15]}}, previous} - {{2{filt_new[15]}}, filt_new};
      ERROR_FORMULA_SELECT_FLT_STPT: diff = {{2{filt_new[15]}}, filt_new} - {{2{setpoint[15]}}, setpoint};
      default:       diff = {{2{error[15]}}, error};
    endcase
    err_new = word_t'(diff);
    ovf_now = ovf_now || (test_now && !fits16(diff)); // R18
    // Signed threshold tests
    unique case (thr.threshold_irq_select) // R23
      3'h0: hit_now = 1'b0; // R16
      3'h1: hit_now = err_new < lower;
      3'h2: hit_now = err_new >= lower;
      3'h3: hit_now = err_new > lower && err_new < upper; // R17
      3'h4: hit_now = err_new < lower || err_new > upper; // R17
      3'h5: hit_now = err_new <= upper;
      3'h6: hit_now = err_new > upper;
      3'h7: hit_now = 1'b1; // R16
    endcase
    // Halt only counts in continuous mode; single shots stop unless a burst average batch is still running
    stop_go = conv_done && ((auto_retrigger_enable && thr.halt_on_irq && test_now && hit_now) // R13 R15
                            || (!auto_retrigger_enable && !burst_more));
  end

  // Sequencing, flags and registered strobes
  always_comb begin
    next_result   = result;
    next_previous = previous;
    next_filter   = filter;
    next_error    = error;
    next_acc      = acc;
    next_count    = count;
    next_pair     = pair;
    next_above    = above;
    next_below    = below;
    next_hit      = 1'b0;
    next_retrig   = 1'b0;
    next_clr_cnt  = clr_start ? CLEAR_COUNT : (clr_busy ? clr_cnt - 2'h1 : clr_cnt); // R9
    next_ovf      = ovf;
    next_upd      = upd;
    if (conv_start) begin
      next_previous = ctrl.previous_source_select ? filter : word_t'({4'h0, result}); // R2
    end
    if (conv_done) begin
      next_result = conv_data;
      next_pair   = (double_sample_enable && pair == PAIR_FIRST) ? PAIR_SECOND : PAIR_FIRST; // R1
      next_retrig = go && !stop_go && (auto_retrigger_enable || burst_more);
    end
    if (compute_now) begin
      next_acc    = acc_new;
      next_count  = cnt_new;
      next_filter = filt_new;
    end
    if (test_now) begin
      next_error = err_new;
      next_above = err_new > upper; // R19
      next_below = err_new < lower; // R19
      next_hit   = hit_now;
    end
    // Software clears by writing zero; set from hardware wins
    if (wr && idx == IDX_COMPUTE_CONDITION) begin
      if (!pwdata[OVF_BIT]) begin
        next_ovf = 1'b0;
      end
      if (!pwdata[UPD_BIT] && phase != PHASE_WAIT) begin
        next_upd = 1'b0; // R20
      end
    end
    if (clr_cnt == 2'h1) begin
      next_acc   = '0; // R8
      next_count = 8'h00;
      next_ovf   = 1'b0;
    end
    if (compute_now) begin
      next_ovf = ovf_now ? 1'b1 : next_ovf; // R18
      next_upd = 1'b1; // R20
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result   <= 12'h000;
      previous <= WORD_RESET;
      filter   <= WORD_RESET;
      error    <= WORD_RESET;
      acc      <= 18'h00000;
      count    <= 8'h00;
      pair     <= PAIR_FIRST;
      clr_cnt  <= 2'h0;
      ovf      <= 1'b0;
      above    <= 1'b0;
      below    <= 1'b0;
      upd      <= 1'b0;
      retrig   <= 1'b0;
      hit      <= 1'b0;
    end else begin
      result   <= next_result;
      previous <= next_previous;
      filter   <= next_filter;
      error    <= next_error;
      acc      <= next_acc;
      count    <= next_count;
      pair     <= next_pair;
      clr_cnt  <= next_clr_cnt;
      ovf      <= next_ovf;
      above    <= next_above;
      below    <= next_below;
      upd      <= next_upd;
      retrig   <= next_retrig;
      hit      <= next_hit;
    end
  end

  assign conv_go        = go;
  assign conv_retrigger = retrig;
  assign threshold_hit  = hit;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_clear_busy_len: assert property ($rose(clr_busy) |-> clr_busy[*3] ##1 !clr_busy) // R9
    else $error("clear busy time wrong");
  a_clear_wipes: assert property ($fell(clr_busy) && !$past(compute_now)
    |-> acc == 18'h00000 && count == 8'h00) // R8
    else $error("accumulator not cleared");
  a_prev_source: assert property (conv_start |=> previous == ($past(ctrl.previous_source_select)
    ? $past(filter) : word_t'({4'h0, $past(result)}))) // R2
    else $error("previous value source wrong");
  a_basic_holds: assert property (conv_done && ctrl.operating_mode_select == MODE_BASIC
    && clr_cnt != 2'h1 |=> $stable(acc) && $stable(filter)) // R5
    else $error("basic mode changed accumulator");
  a_pair_first: assert property (conv_done && double_sample_enable && pair == PAIR_FIRST
    |=> $stable(error) && pair == PAIR_SECOND) // R1
    else $error("first paired sample computed");
  a_halt_stops: assert property (conv_done && auto_retrigger_enable && thr.halt_on_irq && test_now && hit_now
    && !wr |=> !go && !conv_retrigger) // R13
    else $error("go not cleared on hit");
  a_upper_flag: assert property (test_now |=> above == ($past(err_new) > $past(upper))) // R19
    else $error("upper flag wrong");
  a_never_hit: assert property (test_now && thr.threshold_irq_select == 3'h0
    |=> !threshold_hit) // R16
    else $error("never mode raised hit");
  a_upd_locked: assert property (upd && phase == PHASE_WAIT |=> upd) // R20
    else $error("update flag cleared while waiting");
  a_wait_phase: assert property (double_sample_enable && !auto_retrigger_enable && pair == PAIR_SECOND && core_stage == 2'h0
    |-> phase == PHASE_WAIT) // R22
    else $error("phase not 100 between triggers");
  a_ovf_sticky: assert property (ovf && !wr && clr_cnt != 2'h1 |=> ovf) // R18
    else $error("overflow flag dropped");

endmodule

// File: bench/testbench.sv
// Self-checking bench for the ADC computation control block
`timescale 1ns/1ns
module testbench;
  import adc_compute_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        conv_start = 1'b0;
  logic        conv_done = 1'b0;
  sample_t     conv_data = 12'h000;
  logic [1:0]  core_stage = 2'h0;
  logic        conv_go;
  logic        conv_retrigger;
  logic        threshold_hit;
  int          failures = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  logic [31:0] rd;
  logic        err;
  logic        hit;
  logic        rt;

  adc_computation_control u_dut (
    .pclk           (pclk),
    .presetn        (presetn),
    .psel           (psel),
    .penable        (penable),
    .pwrite         (pwrite),
    .paddr          (paddr),
    .pwdata         (pwdata),
    .prdata         (prdata),
    .pready         (pready),
    .pslverr        (pslverr),
    .conv_start     (conv_start),
    .conv_done      (conv_done),
    .conv_data      (conv_data),
    .core_stage     (core_stage),
    .conv_go        (conv_go),
    .conv_retrigger (conv_retrigger),
    .threshold_hit  (threshold_hit)
  );

  // ----------------------------------------------------------------
  // Clock, timeout and shared tasks
  // ----------------------------------------------------------------
  always #5 pclk = ~pclk;

  // A hang counts as a mismatch
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; waits for pready, leaves data in rd and err
  task automatic apb(input logic w, input logic [11:0] idx, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Start, finish, then sample the strobes of the cycle after done
  task automatic convert(input logic [11:0] d);
    @(posedge pclk);
    conv_start <= 1'b1;
    core_stage <= 2'h3;
    @(posedge pclk);
    conv_start <= 1'b0;
    @(posedge pclk);
    conv_done <= 1'b1;
    conv_data <= d;
    @(posedge pclk);
    conv_done <= 1'b0;
    conv_data <= ~d;
    core_stage <= 2'h0;
    @(posedge pclk);
    hit = threshold_hit;
    rt = conv_retrigger;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic s_regs();
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, IDX_COMPUTE_CONTROL + 12'(i), 32'h0);
      check(rd, 32'h0);
    end
    apb(1'b1, IDX_THRESHOLD_CONTROL, 32'h5B);
    apb(1'b0, IDX_THRESHOLD_CONTROL, 32'h0);
    check(rd, 32'h5B);
    apb(1'b0, 12'h001, 32'h0);
    check({31'h0, err}, 32'h1);
  endtask

  // Accumulate two samples, then clear with the busy bit
  task automatic s_accum();
    apb(1'b1, IDX_COMPUTE_CONTROL, 32'h11);
    convert(12'h064);
    convert(12'h03C);
    apb(1'b0, IDX_ACCUMULATOR, 32'h0);
    check(rd, 32'hA0);
    apb(1'b1, IDX_COMPUTE_CONTROL, 32'h19);
    apb(1'b0, IDX_COMPUTE_CONTROL, 32'h0);
    check(rd, 32'h19);
    repeat (6) @(posedge pclk);
    apb(1'b0, IDX_COMPUTE_CONTROL, 32'h0);
    check(rd, 32'h11);
    apb(1'b0, IDX_ACCUMULATOR, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, IDX_SAMPLE_COUNTER, 32'h0);
    check(rd, 32'h0);
  endtask

  // Error -150 against lower -5 and upper 100, every test code
  task automatic s_thresh();
    logic [7:0] exp_hit;
    exp_hit = 8'hB2;
    apb(1'b1, IDX_COMPUTE_CONTROL, 32'h10);
    apb(1'b1, IDX_SETPOINT, 32'hC8);
    apb(1'b1, IDX_LOWER_THRESHOLD, 32'hFFFB);
    apb(1'b1, IDX_UPPER_THRESHOLD, 32'h64);
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, IDX_THRESHOLD_CONTROL, {25'h0, 4'h2, 3'(c)});
      convert(12'h032);
      check({31'h0, hit}, {31'h0, exp_hit[c]});
    end
    apb(1'b0, IDX_ERROR_VALUE, 32'h0);
    check(rd, 32'hFF6A);
    apb(1'b0, IDX_COMPUTE_CONDITION, 32'h0);
    check(rd, 32'h30);
    apb(1'b1, IDX_COMPUTE_CONDITION, 32'h0);
    apb(1'b0, IDX_COMPUTE_CONDITION, 32'h0);
    check(rd, 32'h20);
  endtask

  // Pairing: phase 100 between triggers, clear of update flag ignored
  task automatic s_pair();
    apb(1'b1, IDX_AUX_CONTROL, 32'h1);
    convert(12'h010);
    apb(1'b0, IDX_COMPUTE_CONDITION, 32'h0);
    check({28'h0, rd[4], rd[2:0]}, 32'h4);
    convert(12'h020);
    convert(12'h010);
    apb(1'b1, IDX_COMPUTE_CONDITION, 32'h0);
    apb(1'b0, IDX_COMPUTE_CONDITION, 32'h0);
    check({28'h0, rd[4], rd[2:0]}, 32'hC);
    convert(12'h020);
    apb(1'b0, IDX_COMPUTE_CONDITION, 32'h0);
    check({28'h0, rd[4], rd[2:0]}, 32'h8);
  endtask

  // Continuous: halt stops on a hit, otherwise retrigger
  task automatic s_auto_retrigger_enable();
    apb(1'b1, IDX_AUX_CONTROL, 32'h6);
    apb(1'b1, IDX_THRESHOLD_CONTROL, 32'h1F);
    convert(12'h032);
    check({30'h0, rt, conv_go}, 32'h0);
    apb(1'b1, IDX_AUX_CONTROL, 32'h6);
    apb(1'b1, IDX_THRESHOLD_CONTROL, 32'h17);
    convert(12'h032);
    check({30'h0, rt, conv_go}, 32'h3);
    apb(1'b1, IDX_AUX_CONTROL, 32'h2);
    convert(12'h032);
    check({30'h0, rt, conv_go}, 32'h0);
  endtask

  // Average of two samples with repeat target two to the shift
  task automatic s_avg();
    apb(1'b1, IDX_COMPUTE_CONTROL, 32'h1A);
    apb(1'b1, IDX_REPEAT_TARGET, 32'h2);
    convert(12'h0C8);
    convert(12'h064);
    apb(1'b0, IDX_FILTER_VALUE, 32'h0);
    check(rd, 32'h96);
  endtask

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    s_regs();
    s_accum();
    s_thresh();
    s_pair();
    s_auto_retrigger_enable();
    s_avg();
    tally_and_finish();
  end
endmodule
